// File: design/dcec_event_ctrl.sv
// channel event control: start/abort source selection, force and abort
// assumes a single pclk domain; irq lines and pattern match are synchronous
`timescale 1ns/1ps
`include "dcec_regs.svh"

module dcec_event_ctrl
   import dcec_pkg::*;
#(
   parameter int NIRQ = 256
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic                 pready,
   output logic [31:0]          prdata,
   output logic                 pslverr,
   input  wire logic [NIRQ-1:0] irq_lines,
   input  wire logic            pattern_match,
   input  wire logic            busy,
   output logic                 xfer_start,
   output logic                 xfer_abort,
   output logic                 channel_enable_clr,
   output logic                 channel_abort_flag,
   output logic                 irq
);

   // -----------------------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------------------
   // the select fields are eight bits, so exactly 256 lines are addressable
   if (NIRQ != 256) begin : g_chk
      $error("dcec_event_ctrl: NIRQ must be 256");
   end

   // -----------------------------------------------------------------------
   // state
   // -----------------------------------------------------------------------
   dcec_irq_t  abort_irq_select_r;
   dcec_irq_t  start_irq_select_r;
   logic       pattern_abort_enable_r;
   logic       start_irq_enable_r;
   logic       abort_irq_enable_r;
   dcec_stat_t stat_r;
   dcec_stat_t mask_r;

   logic       wr_acc;
   logic       rd_acc;
   logic       hit_econ;
   logic       hit_stat;
   logic       hit_mask;
   logic       hit_irqin;
   logic       force_req;
   logic       sw_abort_req;
   logic       irq_abort_ev;
   logic       irq_start_ev;
   logic       pat_abort_ev;
   logic       abort_ev;
   logic       start_ev;
   logic [31:0] rd_nxt;

   // -----------------------------------------------------------------------
   // apb decode; zero wait states, so pready is registered high from the first clock after reset
   // -----------------------------------------------------------------------
   assign wr_acc    = psel && penable && pwrite;
   assign rd_acc    = psel && penable && !pwrite;
   assign hit_econ  = (paddr == `DCEC_ECON_OFS);
   assign hit_stat  = (paddr == `DCEC_STAT_OFS);
   assign hit_mask  = (paddr == `DCEC_MASK_OFS);
   assign hit_irqin = (paddr == `DCEC_IRQIN_OFS);

   // self-clearing command bits: pulses only, never stored
   assign force_req    = wr_acc && hit_econ && pwdata[`DCEC_FORCE_BIT];
   assign sw_abort_req = wr_acc && hit_econ && pwdata[`DCEC_SWABT_BIT];

   // -----------------------------------------------------------------------
   // event selection
   // -----------------------------------------------------------------------
   // a plain index picks the line; the muxes are wide but only two per channel, start and abort
   assign irq_abort_ev = abort_irq_enable_r
                       && irq_lines[abort_irq_select_r];
   assign irq_start_ev = start_irq_enable_r
                       && irq_lines[start_irq_select_r];
   assign pat_abort_ev = pattern_abort_enable_r && pattern_match;
   assign abort_ev     = irq_abort_ev || sw_abort_req || pat_abort_ev;
   // abort suppresses any start in the same cycle
   assign start_ev     = (irq_start_ev || force_req) && !abort_ev;

   // -----------------------------------------------------------------------
   // control register writes
   // -----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_irq_select_r     <= `DCEC_SEL_RST;
         start_irq_select_r     <= `DCEC_SEL_RST;
         pattern_abort_enable_r <= `DCEC_EN_RST;
         start_irq_enable_r     <= `DCEC_EN_RST;
         abort_irq_enable_r     <= `DCEC_EN_RST;
      end else if (wr_acc && hit_econ) begin
         // upper byte and low three bits are simply not stored
         abort_irq_select_r     <= pwdata[`DCEC_ABSEL_MSB:`DCEC_ABSEL_LSB];
         start_irq_select_r     <= pwdata[`DCEC_STSEL_MSB:`DCEC_STSEL_LSB];
         pattern_abort_enable_r <= pwdata[`DCEC_PATTERN_ABORT_ENABLE_BIT];
         start_irq_enable_r     <= pwdata[`DCEC_STEN_BIT];
         abort_irq_enable_r     <= pwdata[`DCEC_ABEN_BIT];
      end
   end

   // interrupt mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= 3'h0;
      end else if (wr_acc && hit_mask) begin
         mask_r <= pwdata[`DCEC_NSTAT-1:0];
      end
   end

   // -----------------------------------------------------------------------
   // sticky status; cleared by a read, but a new event wins over the clear
   // -----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= 3'h0;
      end else begin
         stat_r <= ((rd_acc && hit_stat) ? 3'h0 : stat_r)
                 | {pat_abort_ev, start_ev, abort_ev};
      end
   end

   // -----------------------------------------------------------------------
   // transfer engine strobes, all registered
   // -----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer_start         <= 1'b0;
         xfer_abort         <= 1'b0;
         channel_enable_clr <= 1'b0;
      end else begin
         xfer_start         <= start_ev;
         xfer_abort         <= abort_ev;
         channel_enable_clr <= pat_abort_ev;
      end
   end

   // abort flag and interrupt output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_abort_flag <= 1'b0;
         irq                <= 1'b0;
      end else begin
         channel_abort_flag <= stat_r[`DCEC_ST_ABORT]
                            || abort_ev;
         irq                <= |(stat_r & mask_r);
      end
   end

   // -----------------------------------------------------------------------
   // read mux; force and abort bits and unused bits read zero
   // -----------------------------------------------------------------------
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (hit_econ) begin
         rd_nxt[`DCEC_ABSEL_MSB:`DCEC_ABSEL_LSB] = abort_irq_select_r;
         rd_nxt[`DCEC_STSEL_MSB:`DCEC_STSEL_LSB] = start_irq_select_r;
         rd_nxt[`DCEC_PATTERN_ABORT_ENABLE_BIT] = pattern_abort_enable_r;
         rd_nxt[`DCEC_STEN_BIT]  = start_irq_enable_r;
         rd_nxt[`DCEC_ABEN_BIT]  = abort_irq_enable_r;
      end else if (hit_stat) begin
         rd_nxt[`DCEC_NSTAT-1:0] = stat_r;
      end else if (hit_mask) begin
         rd_nxt[`DCEC_NSTAT-1:0] = mask_r;
      end else if (hit_irqin) begin
         rd_nxt[0] = busy;
      end
   end

   // registered read data, captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= !(hit_econ || hit_stat || hit_mask || hit_irqin);
         end
      end
   end

endmodule // dcec_event_ctrl

// File: design/dcec_pkg.sv
// types shared by the channel event control block
// assumes nothing beyond the event control header
package dcec_pkg;
   typedef logic [7:0] dcec_irq_t;
   typedef logic [2:0] dcec_stat_t;
endpackage

// File: design/dcec_regs.svh
// register offsets, field positions, reset values for channel event control
// assumes a 32-bit apb slave; offsets are byte addresses
`ifndef DCEC_REGS_SVH
`define DCEC_REGS_SVH

// -----------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------
`define DCEC_ECON_OFS     12'h000
`define DCEC_STAT_OFS     12'h004
`define DCEC_MASK_OFS     12'h008
`define DCEC_IRQIN_OFS    12'h00C

// -----------------------------------------------------------------------
// field positions of the event control register
// -----------------------------------------------------------------------
`define DCEC_ABSEL_MSB    23
`define DCEC_ABSEL_LSB    16
`define DCEC_STSEL_MSB    15
`define DCEC_STSEL_LSB    8
`define DCEC_FORCE_BIT    7
`define DCEC_SWABT_BIT    6
`define DCEC_PATTERN_ABORT_ENABLE_BIT    5
`define DCEC_STEN_BIT     4
`define DCEC_ABEN_BIT     3

// -----------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------
`define DCEC_SEL_RST      8'hFF
`define DCEC_EN_RST       1'h0

// status bits: abort flag, start event, pattern abort
`define DCEC_ST_ABORT     0
`define DCEC_ST_START     1
`define DCEC_ST_PAT       2
`define DCEC_NSTAT        3

`endif

// File: tb/dcec_checker.sv
// checker: event pulses and control word reads
// assumes binding onto dcec_event_ctrl, one pclk domain
`timescale 1ns/1ps
module dcec_checker #(
   parameter int NIRQ = 256
) (
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [11:0]     paddr,
   input wire logic [31:0]     pwdata,
   input wire logic [31:0]     prdata,
   input wire logic [NIRQ-1:0] irq_lines,
   input wire logic            pattern_match,
   input wire logic            xfer_start,
   input wire logic            xfer_abort,
   input wire logic            channel_enable_clr
);
   logic [31:0] e_r;
   logic        wr0, ab_ev, st_ev, pat_ev;
   // --------------------
   // shadow control word
   // --------------------
   // events at a write edge still see the old word
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) e_r <= 32'h00FF_FF00;
      else if (wr0) e_r <= pwdata;
   assign wr0 = psel & penable & pwrite & (paddr == 12'h000);
   assign pat_ev = e_r[5] & pattern_match;
   assign ab_ev = (e_r[3] & irq_lines[e_r[23:16]])
                | (wr0 & pwdata[6]) | pat_ev;
   assign st_ev = (e_r[4] & irq_lines[e_r[15:8]]) | (wr0 & pwdata[7]);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd0;
      psel && !penable && !pwrite && paddr == 12'h000 ##1 penable;
   endsequence
   chk_abort_pulse: assert property (ab_ev |=> xfer_abort)
      else $error("abort pulse missing");
   chk_abort_quiet: assert property (!ab_ev |=> !xfer_abort)
      else $error("stray abort pulse");
   chk_start_pulse: assert property (
      st_ev && !ab_ev |=> xfer_start) else $error("start pulse missing");
   chk_start_quiet: assert property (
      !st_ev || ab_ev |=> !xfer_start) else $error("stray start pulse");
   chk_pat_clear: assert property (pat_ev |=> channel_enable_clr)
      else $error("enable clear missing");
   chk_pat_quiet: assert property (!pat_ev |=> !channel_enable_clr)
      else $error("stray enable clear");
   chk_pat_abort: assert property (
      pat_ev |=> xfer_abort && !xfer_start)
      else $error("pattern abort missing");
   chk_rd_zeros: assert property (
      s_rd0 |-> prdata[31:24] == 8'h00
      && prdata[7:6] == 2'h0 && prdata[2:0] == 3'h0)
      else $error("bits not zero");
endmodule // dcec_checker
bind dcec_event_ctrl dcec_checker #(.NIRQ(NIRQ)) i_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .irq_lines, .pattern_match, .xfer_start, .xfer_abort, .channel_enable_clr);

// File: tb/dcec_event_ctrl_bench.sv
// bench: apb register checks and event pulse counting
// assumes dcec_event_ctrl beside the far side model
`timescale 1ns/1ps
module dcec_event_ctrl_bench;
   logic         pclk = 1'h0, presetn = 1'h0;
   logic         psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0]  paddr = 12'h000;
   logic [31:0]  pwdata = 32'h0, prdata, rd;
   logic         pready, pslverr, se, pattern_match, busy, irq;
   logic         xfer_start, xfer_abort, channel_enable_clr, channel_abort_flag;
   logic [255:0] irq_lines;
   logic [7:0]   ns = 8'h00, na = 8'h00, nc = 8'h00;
   logic [7:0]   en [4] = '{8'h18, 8'h10, 8'h08, 8'h00};
   logic [23:0]  ex [4] = '{24'h000100, 24'h010000, 24'h000100, 24'h0};
   int           err_total = 0, checks = 0;
   always #25 pclk = ~pclk;
   // pulse counters, so a one-cycle pulse is never missed
   always @(posedge pclk)
      {ns, na, nc} <= {ns + xfer_start, na + xfer_abort,
                       nc + channel_enable_clr};
   dcec_event_ctrl #(.NIRQ(256)) i_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .irq_lines, .pattern_match, .busy, .xfer_start,
      .xfer_abort, .channel_enable_clr, .channel_abort_flag, .irq);
   dcec_far_side i_far (
      .pclk, .presetn, .xfer_start, .xfer_abort, .channel_enable_clr,
      .irq_lines, .pattern_match, .busy);
   // ------------------
   // tasks and scenarios
   // ------------------
   task chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   // request held until pready is seen high at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      se = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // stimulus (control write or far side pulse), then pulse counts
   task ev(input int k, input logic [31:0] w, input logic [23:0] e);
      logic [23:0] p0;
      p0 = {ns, na, nc};
      if (k < 0) apb(1'h1, 12'h000, w);
      else i_far.pulse(k);
      repeat (3) @(posedge pclk);
      chk("pulses", {8'h00, e},
          {8'h00, ns - p0[23:16], na - p0[15:8], nc - p0[7:0]});
   endtask
   task t_regs;
      apb(1'h0, 12'h000, 32'h0);
      chk("reset", 32'h00FF_FF00, rd);
      ev(-1, 32'hFFFF_FFFF, 24'h000100);
      apb(1'h0, 12'h000, 32'h0);
      chk("readback", 32'h00FF_FF38, rd);
      apb(1'h0, 12'h010, 32'h0);
      chk("unmapped", 32'h8000_0000, {se, rd[30:0]});
   endtask
   task t_pat;
      ev(-1, 32'h20, 24'h0);
      ev(256, 32'h0, 24'h000101);
      ev(-1, 32'h0, 24'h0);
      ev(256, 32'h0, 24'h0);
   endtask
   // every enable mix on the selected line, and a neighbour line
   task t_sel(input int n);
      foreach (en[i]) begin
         apb(1'h1, 12'h000, {8'h00, n[7:0], n[7:0], en[i]});
         ev(n, 32'h0, ex[i]);
         ev(n ^ 1, 32'h0, 24'h0);
      end
   endtask
   // start unmasked, abort masked; status read clears
   task t_irq;
      apb(1'h0, 12'h004, 32'h0);
      apb(1'h1, 12'h008, 32'h2);
      ev(-1, 32'h80, 24'h010000);
      chk("irq_flag", 32'h2, {30'h0, irq, channel_abort_flag});
      apb(1'h0, 12'h00C, 32'h0);
      chk("busy", 32'h1, rd);
      apb(1'h0, 12'h004, 32'h0);
      chk("status", 32'h2, rd);
      ev(-1, 32'h40, 24'h000100);
      chk("irq_flag", 32'h1, {30'h0, irq, channel_abort_flag});
   endtask
   task stop_test;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      t_regs;
      t_pat;
      t_sel(0);
      t_sel(255);
      t_sel(90);
      t_irq;
      stop_test;
   end
   // watchdog: run needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge pclk);
      err_total++;
      stop_test;
   end
endmodule // dcec_event_ctrl_bench

// File: tb/dcec_far_side.sv
// model of irq sources and the transfer engine
// assumes the bench calls pulse() from its own process
`timescale 1ns/1ps
module dcec_far_side (
   input  wire logic    pclk,
   input  wire logic    presetn,
   input  wire logic    xfer_start,
   input  wire logic    xfer_abort,
   input  wire logic    channel_enable_clr,
   output logic [255:0] irq_lines,
   output logic         pattern_match,
   output logic         busy
);
   // --------------
   // engine state
   // --------------
   initial begin
      irq_lines = 256'h0;
      pattern_match = 1'h0;
      busy = 1'h0;
   end
   // busy from a start until any abort lands
   always @(posedge pclk or negedge presetn)
      if (!presetn) busy <= 1'h0;
      else if (xfer_abort | channel_enable_clr) busy <= 1'h0;
      else if (xfer_start) busy <= 1'h1;
   // one-cycle pulse; n above 255 means a pattern match
   task pulse(input int n);
      @(posedge pclk);
      if (n > 255) pattern_match <= 1'h1;
      else irq_lines[n] <= 1'h1;
      @(posedge pclk);
      irq_lines <= 256'h0;
      pattern_match <= 1'h0;
   endtask
endmodule // dcec_far_side
